// *** verilog/rxwb_dma.sv ***
// Purpose: Receive buffer manager: stores frames and writes back descriptors
// Assumes: Receive stream and memory port run on sys_clk
// Notes:   One memory request outstanding; bytes wait while it is pending
`timescale 1ns/1ps
`include "rxwb_cfg.svh"
module rxwb_dma #(
	parameter int BUF_BYTES = `RXWB_BUF_BYTES,
	parameter int DESC_MAX  = `RXWB_DESC_MAX
) (
	input  wire logic                sys_clk,
	input  wire logic                rst_n,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire rxwb_pkg::rx_beat_t  rx_beat,
	input  wire rxwb_pkg::rx_match_t rx_match,
	output logic                     rx_ready,
	output rxwb_pkg::mem_req_t       mem_req,
	input  wire rxwb_pkg::mem_rsp_t  mem_rsp
);
	// The byte position counter and word-lane logic assume these shapes
	if (BUF_BYTES < 8 || BUF_BYTES > 128 || (BUF_BYTES % 4) != 0) begin : g_bad_buf
		$error("BUF_BYTES must be a multiple of 4 between 8 and 128");
	end
	if (DESC_MAX < 2 || DESC_MAX > 1024) begin : g_bad_desc
		$error("DESC_MAX must lie between 2 and 1024");
	end

	typedef struct packed {
		rxwb_pkg::eng_state_t st;
		logic                 rdy;
		rxwb_pkg::mem_req_t   req;
		logic [9:0]           qidx;
		logic [31:0]          dw0;
		logic [7:0]           pos;
		logic [3:0]           strb;
		logic [31:0]          wdat;
		logic                 first;
		logic                 sof_buf;
		logic                 done;
		logic [13:0]          len;
		logic [4:0]           fidx;
		logic [15:0]          type_fld;
		logic [15:0]          tci;
		rxwb_pkg::rx_match_t  mt;
		logic                 nobuf_evt;
	} eng_state_s_t;

	eng_state_s_t s_ff;
	eng_state_s_t nxt_s;

	logic [31:0] qbase;
	logic [31:0] cfg;
	logic [31:0] stat_word;
	logic        take;
	logic        keep;
	logic [1:0]  lane;
	logic [7:0]  pos_inc;

	// Register slave
	rxwb_axil_regs u_regs (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.qbase         (qbase),
		.cfg           (cfg),
		.qidx          (s_ff.qidx),
		.busy          (s_ff.st != rxwb_pkg::ST_IDLE),
		.nobuf_evt     (s_ff.nobuf_evt)
	);

	// Status word from registered frame state
	rxwb_stat_fmt u_fmt (
		.mt       (s_ff.mt),
		.type_fld (s_ff.type_fld),
		.tci      (s_ff.tci),
		.tci_seen (s_ff.fidx >= 5'(`RXWB_TCI_BYTE + 2)),
		.sof_buf  (s_ff.sof_buf),
		.eof_buf  (s_ff.done),
		.offset   (cfg[`RXWB_CFG_OFF_LO +: 2]),
		.jumbo    (cfg[`RXWB_CFG_JUMBO]),
		.len      (s_ff.len),
		.word     (stat_word)
	);

	// Descriptor word address inside the list
	function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [9:0] idx);
		return base + {19'h0_0000, idx, 3'b000};
	endfunction

	// Word request builders; every access is one aligned bus word, writes carry byte strobes
	function automatic rxwb_pkg::mem_req_t rd_req(input logic [31:0] a);
		return '{valid: 1'b1, we: 1'b0, addr: a, wdata: 32'h0000_0000, wstrb: 4'h0};
	endfunction

	function automatic rxwb_pkg::mem_req_t wr_req(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		return '{valid: 1'b1, we: 1'b1, addr: a, wdata: d, wstrb: be};
	endfunction

	assign take    = s_ff.rdy && rx_beat.valid;
	// Stripped FCS bytes are consumed but never stored or counted
	assign keep    = !(rx_beat.fcs && cfg[`RXWB_CFG_STRIP]);
	assign lane    = s_ff.pos[1:0];
	assign pos_inc = s_ff.pos + 8'h01;

	// Engine next-state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.nobuf_evt = 1'b0;
		unique case (s_ff.st)
			rxwb_pkg::ST_IDLE: begin
				// Waits without consuming so the first byte lands in the buffer
				if (rx_beat.valid) begin
					if (rx_beat.sof) begin
						nxt_s.first = 1'b1;
						nxt_s.done = 1'b0;
						nxt_s.len = 14'h0000;
						nxt_s.fidx = 5'h00;
						nxt_s.type_fld = 16'h0000;
						nxt_s.tci = 16'h0000;
						nxt_s.mt = '0;
						nxt_s.req = rd_req(desc_addr(qbase, s_ff.qidx));
						nxt_s.st = rxwb_pkg::ST_FETCH;
					end else begin
						nxt_s.st = rxwb_pkg::ST_DROP;
					end
				end
			end
			rxwb_pkg::ST_FETCH: begin
				if (mem_rsp.ack) begin
					nxt_s.req.valid = 1'b0;
					nxt_s.dw0 = mem_rsp.rdata;
					if (mem_rsp.rdata[`RXWB_W0_OWN]) begin
						// Buffer still owned by software: frame is lost
						nxt_s.nobuf_evt = 1'b1;
						nxt_s.st = rxwb_pkg::ST_DROP;
					end else begin
						// Offset only in the first buffer of a frame
						nxt_s.pos = s_ff.first ? {6'h00, cfg[`RXWB_CFG_OFF_LO +: 2]} : 8'h00;
						nxt_s.sof_buf = s_ff.first;
						nxt_s.first = 1'b0;
						nxt_s.strb = 4'h0;
						nxt_s.wdat = 32'h0000_0000;
						nxt_s.st = rxwb_pkg::ST_FILL;
					end
				end
			end
			rxwb_pkg::ST_FILL: begin
				if (take) begin
					// Header bytes for tag decode
					if (s_ff.fidx != 5'h1F) begin
						nxt_s.fidx = s_ff.fidx + 5'h01;
					end
					if (s_ff.fidx == 5'(`RXWB_TYPE_BYTE)) begin
						nxt_s.type_fld[15:8] = rx_beat.data;
					end
					if (s_ff.fidx == 5'(`RXWB_TYPE_BYTE + 1)) begin
						nxt_s.type_fld[7:0] = rx_beat.data;
					end
					if (s_ff.fidx == 5'(`RXWB_TCI_BYTE)) begin
						nxt_s.tci[15:8] = rx_beat.data;
					end
					if (s_ff.fidx == 5'(`RXWB_TCI_BYTE + 1)) begin
						nxt_s.tci[7:0] = rx_beat.data;
					end
					if (keep) begin
						nxt_s.wdat[{lane, 3'b000} +: 8] = rx_beat.data;
						nxt_s.strb[lane] = 1'b1;
						nxt_s.pos = pos_inc;
						nxt_s.len = s_ff.len + 14'h0001;
					end
					if (rx_beat.eof) begin
						nxt_s.done = 1'b1;
						nxt_s.mt = rx_match;
					end
					// Flush on a full word, a full buffer, or frame end
					if ((keep && (lane == 2'b11 || pos_inc == 8'(BUF_BYTES))) ||
					    (rx_beat.eof && nxt_s.strb != 4'h0)) begin
						nxt_s.req = wr_req({s_ff.dw0[31:2], 2'b00} + {24'h00_0000, s_ff.pos[7:2], 2'b00},
						                   nxt_s.wdat, nxt_s.strb);
						nxt_s.st = rxwb_pkg::ST_WDATA;
					end else if (rx_beat.eof) begin
						nxt_s.st = rxwb_pkg::ST_PREP;
					end
				end
			end
			rxwb_pkg::ST_WDATA: begin
				if (mem_rsp.ack) begin
					nxt_s.req.valid = 1'b0;
					nxt_s.strb = 4'h0;
					nxt_s.wdat = 32'h0000_0000;
					if (s_ff.done || s_ff.pos == 8'(BUF_BYTES)) begin
						nxt_s.st = rxwb_pkg::ST_PREP;
					end else begin
						nxt_s.st = rxwb_pkg::ST_FILL;
					end
				end
			end
			rxwb_pkg::ST_PREP: begin
				// Full status only once the frame has ended
				nxt_s.req = wr_req(desc_addr(qbase, s_ff.qidx) + 32'(`RXWB_STAT_OFS), stat_word, 4'hF);
				nxt_s.st = rxwb_pkg::ST_WSTAT;
			end
			rxwb_pkg::ST_WSTAT: begin
				if (mem_rsp.ack) begin
					// Status goes out before ownership so software never sees stale status
					nxt_s.req = wr_req(desc_addr(qbase, s_ff.qidx), s_ff.dw0 | 32'h0000_0001, 4'hF);
					nxt_s.st = rxwb_pkg::ST_WUSED;
				end
			end
			rxwb_pkg::ST_WUSED: begin
				if (mem_rsp.ack) begin
					nxt_s.req.valid = 1'b0;
					// Wrap flag or last permitted entry returns to the list start
					if (s_ff.dw0[`RXWB_W0_WRAP] || s_ff.qidx == 10'(DESC_MAX - 1)) begin
						nxt_s.qidx = 10'h000;
					end else begin
						nxt_s.qidx = s_ff.qidx + 10'h001;
					end
					if (s_ff.done) begin
						nxt_s.st = rxwb_pkg::ST_IDLE;
					end else begin
						nxt_s.req = rd_req(desc_addr(qbase, nxt_s.qidx));
						nxt_s.st = rxwb_pkg::ST_FETCH;
					end
				end
			end
			rxwb_pkg::ST_DROP: begin
				// Discard the rest of the frame
				if (take && rx_beat.eof) begin
					nxt_s.st = rxwb_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_s.st = rxwb_pkg::ST_IDLE;
				nxt_s.req = '0;
			end
		endcase
		nxt_s.rdy = (nxt_s.st == rxwb_pkg::ST_FILL) || (nxt_s.st == rxwb_pkg::ST_DROP);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '{st: rxwb_pkg::ST_IDLE, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign rx_ready = s_ff.rdy;
	assign mem_req  = s_ff.req;

endmodule

// *** verilog/rxwb_cfg.svh ***
// Purpose: Constants for the receive descriptor write-back engine
// Assumes: 32-bit system bus, word-aligned descriptor list
// Notes:   Offsets, field positions, counts, masks and fixed values; no logic here
//
// Functional notes
// - Each receive buffer holds 128 bytes; a full buffer moves on to the next.
// - Buffer start from descriptor is a word address; low two bits ignored.
// - First buffer of a frame starts 0..3 bytes in, from config bits 15:14.
// - A descriptor is two words: address plus control, then written-back status.
// - Overflowed buffer status is zero except start-of-frame and offset bits.
// - A used buffer gets bit 0 of its address word written to one.
// - After marking a full buffer, fetch next descriptor and keep storing data.
// - Complete frame status goes only to the last descriptor of the frame.
// - Word 0 bits 31:2 hold buffer address, bit 1 is the list wrap flag.
// - Data goes only to buffers whose ownership bit is zero; software clears it.
// - Status bits 31..28: broadcast, multicast hash, unicast hash, external; 27 reserved.
// - Status bits 26..23: specific address 1..4 match; bit 22 type ID match.
// - Status bit 21 set when frame type field equals 0x8100.
// - Status bit 20 set for VLAN type with null VLAN identifier.
// - Status bits 19:17 tag priority, bit 16 CFI; valid only with bit 21.
// - Status bit 15 marks frame end; else only bits 14:12 are meaningful.
// - Status bit 14 marks frame start; with bit 15 the buffer holds a whole frame.
// - Status bits 13:12 give first-buffer offset from the current configuration.
// - In jumbo mode (config bit 3) bits 13:12 carry length bits 13:12 instead.
// - Status bits 11:0 hold frame length, FCS counted only when it is stored.
// - After a wrap descriptor or the 1024th one, restart at the list start.
// - Config bit 17 drops the FCS from memory and shortens reported length by four.
`ifndef RXWB_CFG_SVH
`define RXWB_CFG_SVH

// Register map, byte addresses
`define RXWB_REG_QBASE   8'h00
`define RXWB_REG_CFG     8'h04
`define RXWB_REG_STAT    8'h08

// Configuration register fields
`define RXWB_CFG_JUMBO   3
`define RXWB_CFG_OFF_LO  14
`define RXWB_CFG_STRIP   17
`define RXWB_CFG_RST     32'h0000_0000
`define RXWB_CFG_MASK    32'h0002_C008

// Status register fields
`define RXWB_ST_BUSY     0
`define RXWB_ST_NOBUF    1
`define RXWB_ST_IDX_LO   16

// Descriptor layout
`define RXWB_DESC_BYTES  8
`define RXWB_STAT_OFS    4
`define RXWB_W0_OWN      0
`define RXWB_W0_WRAP     1
`define RXWB_BUF_BYTES   128
`define RXWB_DESC_MAX    1024

// Frame parsing
`define RXWB_VLAN_TYPE   16'h8100
`define RXWB_TYPE_BYTE   12
`define RXWB_TCI_BYTE    14

`endif

// *** verilog/rxwb_pkg.sv ***
// Purpose: Types shared by the receive descriptor write-back engine
// Assumes: Single system clock
// Notes:   Constants live in rxwb_cfg.svh
package rxwb_pkg;

	// Byte stream from the receive block
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       sof;
		logic       eof;
		logic       fcs;
	} rx_beat_t;

	// Address checker result, valid with the last byte
	typedef struct packed {
		logic       bcast;
		logic       mhash;
		logic       uhash;
		logic       ext;
		logic [3:0] spec;
		logic       type_id;
	} rx_match_t;

	// Bus master request, held until acknowledged
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} mem_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} mem_rsp_t;

	// Engine states
	typedef enum logic [7:0] {
		ST_IDLE  = 8'b0000_0001,
		ST_FETCH = 8'b0000_0010,
		ST_FILL  = 8'b0000_0100,
		ST_WDATA = 8'b0000_1000,
		ST_PREP  = 8'b0001_0000,
		ST_WSTAT = 8'b0010_0000,
		ST_WUSED = 8'b0100_0000,
		ST_DROP  = 8'b1000_0000
	} eng_state_t;

endpackage

// *** verilog/rxwb_stat_fmt.sv ***
// Purpose: Builds the descriptor status word
// Assumes: Inputs are stable registered engine state
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "rxwb_cfg.svh"
module rxwb_stat_fmt (
	input  wire rxwb_pkg::rx_match_t mt,
	input  wire logic [15:0]         type_fld,
	input  wire logic [15:0]         tci,
	input  wire logic                tci_seen,
	input  wire logic                sof_buf,
	input  wire logic                eof_buf,
	input  wire logic [1:0]          offset,
	input  wire logic                jumbo,
	input  wire logic [13:0]         len,
	output logic      [31:0]         word
);
	logic vlan;
	logic prio_only;

	// Tag decode from captured header bytes
	assign vlan      = tci_seen && (type_fld == `RXWB_VLAN_TYPE);
	assign prio_only = vlan && (tci[11:0] == 12'h000);

	// Middle and overflow buffers carry only start and offset
	always_comb begin
		word = 32'h0000_0000;
		word[14] = sof_buf;
		word[13:12] = sof_buf ? offset : 2'b00;
		if (eof_buf) begin
			word[31] = mt.bcast;
			word[30] = mt.mhash;
			word[29] = mt.uhash;
			word[28] = mt.ext;
			word[26:23] = {mt.spec[0], mt.spec[1], mt.spec[2], mt.spec[3]};
			word[22] = mt.type_id;
			word[21] = vlan;
			word[20] = prio_only;
			word[19:17] = vlan ? tci[15:13] : 3'b000;
			word[16] = vlan ? tci[12] : 1'b0;
			word[15] = 1'b1;
			word[11:0] = len[11:0];
			if (jumbo) begin
				word[13:12] = len[13:12];
			end
		end
	end

endmodule

// *** verilog/rxwb_axil_regs.sv ***
// Purpose: AXI4-Lite register slave for the write-back engine
// Assumes: One write and one read outstanding at most
// Notes:   Unmapped addresses answer DECERR, read data zero
`timescale 1ns/1ps
`include "rxwb_cfg.svh"
module rxwb_axil_regs (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      qbase,
	output logic [31:0]      cfg,
	input  wire logic [9:0]  qidx,
	input  wire logic        busy,
	input  wire logic        nobuf_evt
);
	typedef struct packed {
		logic        awrdy;
		logic        wrdy;
		logic        aw_hold;
		logic        w_hold;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arrdy;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] qbase;
		logic [31:0] cfg;
		logic        nobuf;
	} regs_state_t;

	regs_state_t s_ff;
	regs_state_t nxt_s;

	// Byte-lane merge used by both writable registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		nxt_s = s_ff;
		// Address and data may come in either order
		if (s_axi_awvalid && s_ff.awrdy) begin
			nxt_s.aw_hold = 1'b1;
			nxt_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wrdy) begin
			nxt_s.w_hold = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// Commit once both halves are held
		if (s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid) begin
			nxt_s.aw_hold = 1'b0;
			nxt_s.w_hold = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = 2'b00;
			unique case (s_ff.awaddr)
				`RXWB_REG_QBASE: nxt_s.qbase = merge(s_ff.qbase, s_ff.wdata, s_ff.wstrb) & 32'hFFFF_FFFC;
				`RXWB_REG_CFG:   nxt_s.cfg = merge(s_ff.cfg, s_ff.wdata, s_ff.wstrb) & `RXWB_CFG_MASK;
				`RXWB_REG_STAT: begin
					if (s_ff.wstrb[0] && s_ff.wdata[`RXWB_ST_NOBUF]) begin
						nxt_s.nobuf = 1'b0;
					end
				end
				default: nxt_s.bresp = 2'b11;
			endcase
		end
		// Set wins over a software clear in the same cycle
		if (nobuf_evt) begin
			nxt_s.nobuf = 1'b1;
		end
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_ff.arrdy) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = 2'b00;
			nxt_s.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				`RXWB_REG_QBASE: nxt_s.rdata = s_ff.qbase;
				`RXWB_REG_CFG:   nxt_s.rdata = s_ff.cfg;
				`RXWB_REG_STAT: begin
					nxt_s.rdata[`RXWB_ST_BUSY] = busy;
					nxt_s.rdata[`RXWB_ST_NOBUF] = s_ff.nobuf;
					nxt_s.rdata[`RXWB_ST_IDX_LO +: 10] = qidx;
				end
				default: nxt_s.rresp = 2'b11;
			endcase
		end
		nxt_s.awrdy = !nxt_s.aw_hold && !nxt_s.bvalid;
		nxt_s.wrdy = !nxt_s.w_hold && !nxt_s.bvalid;
		nxt_s.arrdy = !nxt_s.rvalid;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_ff <= '{awrdy: 1'b1, wrdy: 1'b1, arrdy: 1'b1, cfg: `RXWB_CFG_RST, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign s_axi_awready = s_ff.awrdy;
	assign s_axi_wready  = s_ff.wrdy;
	assign s_axi_bvalid  = s_ff.bvalid;
	assign s_axi_bresp   = s_ff.bresp;
	assign s_axi_arready = s_ff.arrdy;
	assign s_axi_rvalid  = s_ff.rvalid;
	assign s_axi_rdata   = s_ff.rdata;
	assign s_axi_rresp   = s_ff.rresp;
	assign qbase         = s_ff.qbase;
	assign cfg           = s_ff.cfg;

endmodule

// *** sim/rxwb_dma_chk.sv ***
// Purpose: Port-level checks of the receive write-back engine
// Assumes: One clock, rst_n asynchronous active low
// Notes:   Bound to every rxwb_dma instance
`timescale 1ns/1ps
module rxwb_dma_chk (
	input wire logic                sys_clk,
	input wire logic                rst_n,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire rxwb_pkg::rx_beat_t  rx_beat,
	input wire logic                rx_ready,
	input wire rxwb_pkg::mem_req_t  mem_req,
	input wire rxwb_pkg::mem_rsp_t  mem_rsp
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Both write halves taken on one edge; memory request still waiting
	sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_req_wait; mem_req.valid && !mem_rsp.ack; endsequence

	// Register slave answer timing
	property p_b_lat; s_wr_take |-> ##2 s_axi_bvalid; endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read data late");
	property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_block: assert property (p_b_block) else $error("new write taken under pending response");
	property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_r_once: assert property (p_r_once) else $error("read data repeated");

	// Memory master holds each word access until acknowledged
	property p_req_hold; s_req_wait |=> mem_req.valid && $stable(mem_req); endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request changed early");
	property p_word; mem_req.valid |-> mem_req.addr[1:0] == 2'b00; endproperty
	a_word: assert property (p_word) else $error("memory access not word aligned");

	// Bytes are taken only while no memory access is pending
	property p_rx_quiet; rx_beat.valid && rx_ready |-> !mem_req.valid; endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("byte taken during memory access");
endmodule

bind rxwb_dma rxwb_dma_chk chk_u (.*);

// *** sim/rxwb_mem_model.sv ***
// Purpose: System memory holding descriptor list and buffers
// Assumes: Word accesses, one request at a time
// Notes:   Answer delay varies 0..2 cycles between requests
`timescale 1ns/1ps
module rxwb_mem_model (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire rxwb_pkg::mem_req_t mem_req,
	output rxwb_pkg::mem_rsp_t      mem_rsp
);
	logic [31:0] mem [int];
	logic [31:0] w;
	int          lag;
	int          n;

	// Skip the ack edge itself, the request there is stale; read data toggles when idle
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_rsp <= '0;
			lag     <= 0;
			n       <= 0;
		end else if (mem_req.valid && !mem_rsp.ack && lag < n % 3) begin
			lag     <= lag + 1;
			mem_rsp <= {1'b0, ~mem_rsp.rdata};
		end else if (mem_req.valid && !mem_rsp.ack) begin
			w = mem.exists(int'(mem_req.addr)) ? mem[int'(mem_req.addr)] : 32'h0000_0000;
			for (int b = 0; b < 4; b++) begin
				if (mem_req.we && mem_req.wstrb[b]) w[8*b +: 8] = mem_req.wdata[8*b +: 8];
			end
			if (mem_req.we) mem[int'(mem_req.addr)] = w;
			lag     <= 0;
			n       <= n + 1;
			mem_rsp <= {1'b1, mem_req.we ? ~w : w};
		end else begin
			mem_rsp <= {1'b0, ~mem_rsp.rdata};
		end
	end
endmodule

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the receive write-back engine
// Assumes: rxwb_mem_model stands in for system memory
// Notes:   Three descriptors at 0x1000, the third wraps
`timescale 1ns/1ps
module testbench;
	logic                sys_clk = 1'b0;
	logic                rst_n = 1'b0;
	logic [7:0]          s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]         s_axi_wdata = 32'h0000_0000;
	logic [3:0]          s_axi_wstrb = 4'hF;
	logic                s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic                s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_ready;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic [31:0]         s_axi_rdata;
	rxwb_pkg::rx_beat_t  rx_beat = '0;
	rxwb_pkg::rx_match_t rx_match = '0;
	rxwb_pkg::mem_req_t  mem_req;
	rxwb_pkg::mem_rsp_t  mem_rsp;
	int                  error_cnt = 0;
	int                  comparisons = 0;

	rxwb_dma #(.DESC_MAX(4)) dut_u (.*);
	rxwb_mem_model mem_u (.*);

	// 50 MHz system clock
	always #10 sys_clk = ~sys_clk;

	task automatic tally_and_finish;
		if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic timeout;
		error_cnt++;
		$display("[ERR] %0t wait ran out", $time);
		tally_and_finish();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Register write; each half released at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int   t;
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		b_t = 1'b0;
		for (t = 0; t < 50 && !b_t; t++) begin
			@(negedge sys_clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t  = s_axi_wvalid && s_axi_wready;
			b_t  = s_axi_bvalid;
			r    = s_axi_bresp;
			@(posedge sys_clk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) s_axi_bready <= 1'b0;
		end
		if (!b_t) timeout();
		chk({30'h0, r}, {30'h0, er});
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
		int   t;
		logic ar_t, r_t;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		r_t = 1'b0;
		for (t = 0; t < 50 && !r_t; t++) begin
			@(negedge sys_clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t  = s_axi_rvalid;
			d    = s_axi_rdata;
			rr   = s_axi_rresp;
			@(posedge sys_clk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) s_axi_rready <= 1'b0;
		end
		if (!r_t) timeout();
		@(posedge sys_clk);
	endtask

	// Frame byte: counting pattern, VLAN tag at bytes 12..15 when tci is nonzero
	function automatic logic [7:0] bt(input int k, input logic [15:0] tci);
		if (tci != 16'h0000 && k >= 12 && k < 16)
			return (k == 12) ? 8'h81 : (k == 13) ? 8'h00 : (k == 14) ? tci[15:8] : tci[7:0];
		return k[7:0];
	endfunction

	task automatic send(input int n, input int nfcs, input logic [15:0] tci);
		int t;
		for (int k = 0; k < n; k++) begin
			rx_beat <= '{1'b1, bt(k, tci), k == 0, k == n - 1, k >= n - nfcs};
			t = 0;
			do begin
				@(negedge sys_clk);
				t++;
			end while (!rx_ready && t < 400);
			if (t >= 400) timeout();
			@(posedge sys_clk);
		end
		rx_beat <= '0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  rr;
		rd(a, d, rr);
		chk(d, exp);
		chk({30'h0, rr}, {30'h0, er});
	endtask

	// Busy is polled rather than waited out, memory delay varies
	task automatic wait_idle;
		int          t;
		logic [31:0] d;
		logic [1:0]  rr;
		d = 32'h0000_0001;
		for (t = 0; t < 300 && d[0] !== 1'b0; t++) rd(8'h08, d, rr);
		if (t >= 300) timeout();
	endtask

	initial begin
		#2_000_000;
		timeout();
	end

	initial begin
		mem_u.mem[32'h1000] = 32'h0000_2000;
		mem_u.mem[32'h1008] = 32'h0000_2080;
		mem_u.mem[32'h1010] = 32'h0000_2102;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		rc(8'h00, 32'h0000_0000, 2'b00);
		wr(8'h04, 32'hFFFF_FFFF, 2'b00);
		rc(8'h04, 32'h0002_C008, 2'b00);
		wr(8'h0C, 32'h0000_0001, 2'b11);
		rc(8'h0C, 32'h0000_0000, 2'b11);
		wr(8'h00, 32'h0000_1003, 2'b00);
		rc(8'h00, 32'h0000_1000, 2'b00);
		// Whole VLAN frame, offset two
		wr(8'h04, 32'h0000_8000, 2'b00);
		rx_match <= '{1'b1, 1'b0, 1'b0, 1'b0, 4'b0001, 1'b0};
		send(60, 0, 16'hA000);
		wait_idle();
		chk(mem_u.mem[32'h1004], 32'h843A_E03C);
		chk(mem_u.mem[32'h1000], 32'h0000_2001);
		chk(mem_u.mem[32'h2004], 32'h0504_0302);
		// Two-buffer frame, FCS stripped
		wr(8'h04, 32'h0002_0000, 2'b00);
		rx_match <= '{1'b0, 1'b0, 1'b1, 1'b0, 4'b0000, 1'b0};
		send(200, 4, 16'h0000);
		wait_idle();
		chk(mem_u.mem[32'h100C], 32'h0000_4000);
		chk(mem_u.mem[32'h1014], 32'h2000_80C4);
		chk(mem_u.mem[32'h1008], 32'h0000_2081);
		chk(mem_u.mem[32'h1010], 32'h0000_2103);
		chk(mem_u.mem[32'h20FC], 32'h7F7E_7D7C);
		chk(mem_u.mem[32'h2100], 32'h8382_8180);
		// Wrapped onto an owned descriptor: frame dropped
		send(20, 0, 16'h0000);
		wait_idle();
		rc(8'h08, 32'h0000_0002, 2'b00);
		chk(mem_u.mem[32'h1004], 32'h843A_E03C);
		wr(8'h08, 32'h0000_0002, 2'b00);
		rc(8'h08, 32'h0000_0000, 2'b00);
		mem_u.mem[32'h1000] = 32'h0000_2000;
		// Jumbo: length bits replace the offset field
		wr(8'h04, 32'h0000_C008, 2'b00);
		rx_match <= '{1'b0, 1'b1, 1'b0, 1'b1, 4'b1000, 1'b1};
		send(20, 0, 16'h0000);
		wait_idle();
		chk(mem_u.mem[32'h1004], 32'h50C0_C014);
		chk(mem_u.mem[32'h2004], 32'h0403_0201);
		rc(8'h08, 32'h0001_0000, 2'b00);
		tally_and_finish();
	end
endmodule
